// ==== src/cmb_top.v ====
// Summary of operation
// - pending transmit buffers enter arbitration once the bus is free
// - the chosen transmit buffer is copied into the serial buffer
// - transmit length above eight is sent as eight bytes
// - on send success store time stamp, update code, set flag
// - control write during arbitration withdraws that buffer
// - control write during copy cancels the frame
// - control write after copy: frame still sent, no flag, code kept
// - lowest identifier withdrawn during arbitration may go unsent
// - own sent data frames are received into a matching empty buffer
// - every good received data frame is compared with active receive buffers
// - lowest match gets stamp, identifier, data, length, code and flag
// - control read locks a receive buffer; timer read or other lock frees
// - frame for a locked buffer waits silently until release
// - only the latest waiting frame is kept
// - control read during inbound move shows busy and does not lock
// - control write during inbound move halts it without flag
// - data write during inbound move leaves full or overrun, no flag
// - remote request buffer sends remote frame then becomes receive buffer
// - received remote frame triggers exact-identifier response, not stored
// - overload only on dominant in set intermission, end or delimiter bits
// - a free-running 16-bit timer is sampled at identifier start
`timescale 1ns/1ns
`include "cmb_regs.vh"
module cmb_top #(
    parameter NBUF = 16,
    parameter IW = 4
) (
    input wire I_CLOCK,             // system clock
    input wire I_NRST,              // synchronous reset, active low
    input wire [7:0] I_ADDR,        // register address
    input wire [15:0] I_WDATA,      // register write data
    input wire I_WR,                // write strobe
    input wire I_RD,                // read strobe
    output wire [15:0] O_RDATA,     // read data, cycle after strobe
    input wire I_BUS_FREE,          // bus idle or inter-frame space
    input wire I_ID_START,          // identifier field begins
    input wire I_TX_DONE,           // transmission succeeded
    input wire I_TX_LOST,           // transmission abandoned
    input wire I_RX_VALID,          // error-free frame received
    input wire [31:0] I_RX_ID,      // received identifier, bit 0 remote
    input wire [3:0] I_RX_LEN,      // received length
    input wire [63:0] I_RX_DATA,    // received data, byte 0 on top
    output reg O_TX_REQ,            // serial buffer holds a frame to send
    output reg [31:0] O_TX_ID,      // identifier to send
    output reg [3:0] O_TX_LEN,      // length to send
    output reg [63:0] O_TX_DATA,    // data to send
    input wire I_BIT_VALID,         // one bit sampled
    input wire I_BIT_DOM,           // sampled bit is dominant
    input wire [1:0] I_FIELD,       // current frame field
    input wire [2:0] I_BIT_POS,     // bit index in field
    input wire I_RX_FRAME,          // current frame is a received one
    output reg O_OVERLOAD           // start an overload frame
);
    localparam ST_IDLE = 3'd0;
    localparam ST_ARB = 3'd1;
    localparam ST_COPY = 3'd2;
    localparam ST_WAIT = 3'd3;
    localparam ST_MOVE = 3'd4;

    reg [3:0] code [0:NBUF-1];
    reg [3:0] blen [0:NBUF-1];
    reg [15:0] id_hi [0:NBUF-1];
    reg [15:0] id_lo [0:NBUF-1];
    reg [2:0] st;
    reg [IW-1:0] cnt;
    reg [IW-1:0] sel_idx;
    reg [31:0] best_id;
    reg best_ok;
    reg deact;
    reg mv_hit;
    reg rx_pend;
    reg rx_self;
    reg [31:0] smb_id;
    reg [3:0] smb_len;
    reg [63:0] smb_data;
    reg [15:0] smb_stamp;
    reg [15:0] stamp_cap;
    reg [15:0] timer;
    reg lock_ok;
    reg [IW-1:0] lock_idx;
    reg [NBUF-1:0] flags;
    reg [31:0] mask;
    reg srst;
    reg [15:0] rd_reg;
    reg rd_mem;
    wire [15:0] a_rdata;
    wire [15:0] b_rdata;
    wire rst = !I_NRST || srst;

    // ==========================================
    // host decode
    wire h_buf = !I_ADDR[7];
    wire [IW-1:0] h_idx = I_ADDR[IW+2:3];
    wire [2:0] h_word = I_ADDR[2:0];
    wire h_ctrl_wr = I_WR && h_buf && h_word == `CMB_W_CTRL;
    wire h_ctrl_rd = I_RD && h_buf && h_word == `CMB_W_CTRL;
    wire h_sel_wr = h_ctrl_wr && h_idx == sel_idx;
    wire h_busy = st == ST_MOVE && h_idx == sel_idx;
    wire [3:0] h_code = code[h_idx] | (h_busy ? `CMB_BUSY : 4'h0);
    wire h_mv_data = I_WR && h_buf && h_word != `CMB_W_CTRL && h_idx == sel_idx;

    // ==========================================
    // match search over all buffers, lowest index wins
    reg m_ok;
    reg [IW-1:0] m_idx;
    reg r_ok;
    reg [IW-1:0] r_idx;
    reg any_tx;
    reg rxa;
    integer i;
    integer k;
    always @* begin
        m_ok = 1'b0;
        m_idx = {IW{1'b0}};
        r_ok = 1'b0;
        r_idx = {IW{1'b0}};
        any_tx = 1'b0;
        rxa = 1'b0;
        for (i = NBUF - 1; i >= 0; i = i - 1) begin
            rxa = code[i] == `CMB_RX_EMPTY || code[i] == `CMB_RX_FULL ||
                code[i] == `CMB_RX_OVR;
            if (rxa && (!rx_self || code[i] == `CMB_RX_EMPTY) &&
                    ((smb_id ^ {id_hi[i], id_lo[i]}) & mask) == 32'h0) begin
                m_ok = 1'b1;
                m_idx = i[IW-1:0];
            end
            if (code[i] == `CMB_TX_RRESP &&
                    ((smb_id ^ {id_hi[i], id_lo[i]}) & 32'hfffffffe) == 32'h0) begin
                r_ok = 1'b1;
                r_idx = i[IW-1:0];
            end
            if (code[i] == `CMB_TX_SEND || code[i] == `CMB_TX_RSEND) begin
                any_tx = 1'b1;
            end
        end
    end

    // ==========================================
    // engine outputs toward code, flags and memory
    reg e_code_we;
    reg [IW-1:0] e_code_idx;
    reg [3:0] e_code_val;
    reg e_len_we;
    reg e_flag;
    reg b_we;
    reg [2:0] b_word;
    reg [15:0] b_wdata;
    wire [IW-1:0] b_idx = sel_idx;
    wire [3:0] cand_code = code[cnt];
    wire [31:0] cand_id = {id_hi[cnt], id_lo[cnt]};
    wire cand = (cand_code == `CMB_TX_SEND || cand_code == `CMB_TX_RSEND) &&
        !(h_ctrl_wr && h_idx == cnt);
    wire mv_last = cnt[2:0] == `CMB_MOVE_LAST;
    wire tx_rtr = O_TX_ID[`CMB_RTR_BIT];
    always @* begin
        e_code_we = 1'b0;
        e_code_idx = sel_idx;
        e_code_val = `CMB_TX_INACT;
        e_len_we = 1'b0;
        e_flag = 1'b0;
        b_we = 1'b0;
        b_word = `CMB_W_DATA0 + cnt[2:0];
        b_wdata = smb_stamp;
        case (st)
            ST_IDLE: begin
                if (rx_pend && smb_id[`CMB_RTR_BIT] && !rx_self && r_ok) begin
                    e_code_we = 1'b1;
                    e_code_idx = r_idx;
                    e_code_val = `CMB_TX_RSEND;
                end
            end
            ST_WAIT: begin
                if (I_TX_DONE && !deact && !h_sel_wr) begin
                    b_we = 1'b1;
                    b_word = `CMB_W_STAMP;
                    b_wdata = stamp_cap;
                    e_code_we = 1'b1;
                    e_code_val = tx_rtr ? `CMB_RX_EMPTY :
                        (code[sel_idx] == `CMB_TX_RSEND ? `CMB_TX_RRESP : `CMB_TX_INACT);
                    e_flag = 1'b1;
                end
            end
            ST_MOVE: begin
                b_we = !h_sel_wr;
                b_word = cnt[2:0] + `CMB_W_IDHI;
                case (cnt[2:0])
                    3'h0: b_wdata = smb_id[31:16];
                    3'h1: b_wdata = smb_id[15:0];
                    3'h2: b_wdata = smb_data[63:48];
                    3'h3: b_wdata = smb_data[47:32];
                    3'h4: b_wdata = smb_data[31:16];
                    3'h5: b_wdata = smb_data[15:0];
                    default: b_wdata = smb_stamp;
                endcase
                if (mv_last && !h_sel_wr) begin
                    e_code_we = 1'b1;
                    e_len_we = 1'b1;
                    e_code_val = code[sel_idx] == `CMB_RX_EMPTY ? `CMB_RX_FULL : `CMB_RX_OVR;
                    e_flag = !mv_hit && !h_mv_data;
                end
            end
            default: begin
                b_we = 1'b0;
            end
        endcase
    end

    // ==========================================
    // buffer codes, lengths and identifier shadows, host write wins
    always @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            for (k = 0; k < NBUF; k = k + 1) begin
                code[k] <= `CMB_RX_INACT;
            end
        end else begin
            if (e_code_we) begin
                code[e_code_idx] <= e_code_val;
            end
            if (e_len_we) begin
                blen[sel_idx] <= smb_len;
            end
            if (b_we && b_word == `CMB_W_IDHI) begin
                id_hi[sel_idx] <= b_wdata;
            end
            if (b_we && b_word == `CMB_W_IDLO) begin
                id_lo[sel_idx] <= b_wdata;
            end
            if (h_ctrl_wr) begin
                code[h_idx] <= I_WDATA[`CMB_CODE_MSB:`CMB_CODE_LSB];
                blen[h_idx] <= I_WDATA[`CMB_LEN_MSB:`CMB_LEN_LSB];
            end
            if (I_WR && h_buf && h_word == `CMB_W_IDHI) begin
                id_hi[h_idx] <= I_WDATA;
            end
            if (I_WR && h_buf && h_word == `CMB_W_IDLO) begin
                id_lo[h_idx] <= I_WDATA;
            end
        end
    end

    // ==========================================
    // transfer engine
    always @(posedge I_CLOCK) begin
        if (rst) begin
            st <= ST_IDLE;
            cnt <= {IW{1'b0}};
            sel_idx <= {IW{1'b0}};
            best_id <= 32'h0;
            best_ok <= 1'b0;
            deact <= 1'b0;
            mv_hit <= 1'b0;
            rx_pend <= 1'b0;
            rx_self <= 1'b0;
            O_TX_REQ <= 1'b0;
            O_TX_ID <= 32'h0;
            O_TX_LEN <= 4'h0;
            O_TX_DATA <= 64'h0;
        end else begin
            case (st)
                ST_IDLE: begin
                    cnt <= {IW{1'b0}};
                    best_ok <= 1'b0;
                    mv_hit <= 1'b0;
                    if (rx_pend) begin
                        if (smb_id[`CMB_RTR_BIT] && !rx_self) begin
                            rx_pend <= 1'b0;
                        end else if (!m_ok) begin
                            rx_pend <= 1'b0;
                        end else if (!(lock_ok && lock_idx == m_idx)) begin
                            sel_idx <= m_idx;
                            st <= ST_MOVE;
                        end
                    end else if (I_BUS_FREE && any_tx) begin
                        st <= ST_ARB;
                    end
                end
                ST_ARB: begin
                    if (cand && (!best_ok || cand_id < best_id)) begin
                        best_ok <= 1'b1;
                        best_id <= cand_id;
                        sel_idx <= cnt;
                    end else if (h_sel_wr) begin
                        best_ok <= 1'b0;
                    end
                    cnt <= cnt + 1'b1;
                    if (cnt == NBUF - 1) begin
                        cnt <= {IW{1'b0}};
                        st <= ST_COPY;
                    end
                end
                ST_COPY: begin
                    cnt <= cnt + 1'b1;
                    if (cnt != {IW{1'b0}}) begin
                        O_TX_DATA <= {O_TX_DATA[47:0], b_rdata};
                    end
                    if (!best_ok || h_sel_wr) begin
                        st <= ST_IDLE;
                    end else if (cnt[2:0] == `CMB_COPY_LAST) begin
                        O_TX_REQ <= 1'b1;
                        O_TX_ID <= {id_hi[sel_idx], id_lo[sel_idx]};
                        O_TX_LEN <= blen[sel_idx] > `CMB_MAX_LEN ? `CMB_MAX_LEN :
                            blen[sel_idx];
                        deact <= 1'b0;
                        st <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (h_sel_wr) begin
                        deact <= 1'b1;
                    end
                    if (I_TX_LOST) begin
                        O_TX_REQ <= 1'b0;
                        st <= ST_IDLE;
                    end else if (I_TX_DONE) begin
                        O_TX_REQ <= 1'b0;
                        st <= ST_IDLE;
                        if (!tx_rtr) begin
                            rx_pend <= 1'b1;
                            rx_self <= 1'b1;
                            smb_id <= O_TX_ID;
                            smb_len <= O_TX_LEN;
                            smb_data <= O_TX_DATA;
                            smb_stamp <= stamp_cap;
                        end
                    end
                end
                ST_MOVE: begin
                    cnt <= cnt + 1'b1;
                    if (h_mv_data) begin
                        mv_hit <= 1'b1;
                    end
                    if (h_sel_wr || mv_last) begin
                        rx_pend <= 1'b0;
                        st <= ST_IDLE;
                    end
                end
                default: begin
                    st <= ST_IDLE;
                end
            endcase
            if (I_RX_VALID) begin
                rx_pend <= 1'b1;
                rx_self <= 1'b0;
                smb_id <= I_RX_ID;
                smb_len <= I_RX_LEN;
                smb_data <= I_RX_DATA;
                smb_stamp <= stamp_cap;
            end
        end
    end

    // ==========================================
    // timer, stamp capture, lock, flags and mask
    always @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            timer <= 16'h0;
            stamp_cap <= 16'h0;
        end else begin
            timer <= timer + 16'h1;
            if (I_ID_START) begin
                stamp_cap <= timer;
            end
        end
    end

    always @(posedge I_CLOCK) begin
        if (rst) begin
            lock_ok <= 1'b0;
            lock_idx <= {IW{1'b0}};
        end else if (I_RD && I_ADDR == `CMB_ADDR_TIMER) begin
            lock_ok <= 1'b0;
        end else if (h_ctrl_rd && !h_code[3] && !h_busy) begin
            lock_ok <= 1'b1;
            lock_idx <= h_idx;
        end
    end

    always @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            flags <= {NBUF{1'b0}};
            mask <= {`CMB_MASK_RST, `CMB_MASK_RST};
            srst <= 1'b0;
        end else begin
            srst <= I_WR && I_ADDR == `CMB_ADDR_CFG && I_WDATA[`CMB_CFG_SRST];
            // write one to clear, a new event wins
            flags <= (flags & ~((I_WR && I_ADDR == `CMB_ADDR_FLAGS) ?
                I_WDATA[NBUF-1:0] : {NBUF{1'b0}})) |
                ({{(NBUF-1){1'b0}}, e_flag} << sel_idx);
            if (I_WR && I_ADDR == `CMB_ADDR_MASK_HI) begin
                mask[31:16] <= I_WDATA;
            end
            if (I_WR && I_ADDR == `CMB_ADDR_MASK_LO) begin
                mask[15:0] <= I_WDATA;
            end
        end
    end

    // ==========================================
    // read data, memory words bypass its register and come from the memory read port
    always @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            rd_reg <= 16'h0;
            rd_mem <= 1'b0;
        end else begin
            rd_reg <= 16'h0;
            rd_mem <= I_RD && h_buf && h_word >= `CMB_W_DATA0;
            if (I_RD && h_buf) begin
                case (h_word)
                    `CMB_W_CTRL: rd_reg <= {8'h0, h_code, blen[h_idx]};
                    `CMB_W_IDHI: rd_reg <= id_hi[h_idx];
                    `CMB_W_IDLO: rd_reg <= id_lo[h_idx];
                    default: rd_reg <= 16'h0;
                endcase
            end else if (I_RD) begin
                case (I_ADDR)
                    `CMB_ADDR_TIMER: rd_reg <= timer;
                    `CMB_ADDR_FLAGS: rd_reg <= flags;
                    `CMB_ADDR_MASK_HI: rd_reg <= mask[31:16];
                    `CMB_ADDR_MASK_LO: rd_reg <= mask[15:0];
                    `CMB_ADDR_CFG: rd_reg <= {lock_ok, lock_idx, O_TX_REQ, rx_pend, 6'h0, st};
                    default: rd_reg <= 16'h0;
                endcase
            end
        end
    end
    assign O_RDATA = rd_mem ? a_rdata : rd_reg;

    // ==========================================
    // overload start detection
    always @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            O_OVERLOAD <= 1'b0;
        end else begin
            O_OVERLOAD <= I_BIT_VALID && I_BIT_DOM &&
                ((I_FIELD == `CMB_FLD_INTER && I_BIT_POS <= `CMB_POS_INTER_LAST) ||
                (I_FIELD == `CMB_FLD_EOF && I_BIT_POS == `CMB_POS_EOF_LAST && I_RX_FRAME) ||
                (I_FIELD == `CMB_FLD_DELIM && I_BIT_POS == `CMB_POS_DELIM_LAST));
        end
    end

    cmb_mem #(.DW(16), .AW(IW + 3)) u_mem (
        .clk(I_CLOCK),
        .a_addr(I_ADDR[IW+2:0]),
        .a_we(I_WR && h_buf && h_word >= `CMB_W_DATA0),
        .a_wdata(I_WDATA),
        .a_rdata(a_rdata),
        .b_addr({b_idx, b_word}),
        .b_we(b_we),
        .b_wdata(b_wdata),
        .b_rdata(b_rdata)
    );
endmodule // cmb_top

// ==== src/cmb_regs.vh ====
`ifndef CMB_REGS_VH
`define CMB_REGS_VH
// ==========================================
// register map, low bank holds the buffers
`define CMB_ADDR_TIMER 8'h80
`define CMB_ADDR_FLAGS 8'h81
`define CMB_ADDR_MASK_HI 8'h82
`define CMB_ADDR_MASK_LO 8'h83
`define CMB_ADDR_CFG 8'h84
// ==========================================
// word positions inside one buffer
`define CMB_W_CTRL 3'h0
`define CMB_W_IDHI 3'h1
`define CMB_W_IDLO 3'h2
`define CMB_W_DATA0 3'h3
`define CMB_W_STAMP 3'h7
// ==========================================
// control/status word fields
`define CMB_CODE_MSB 7
`define CMB_CODE_LSB 4
`define CMB_LEN_MSB 3
`define CMB_LEN_LSB 0
`define CMB_CFG_SRST 0
`define CMB_RTR_BIT 0
// ==========================================
// buffer codes, busy is code bit 0
`define CMB_RX_INACT 4'h0
`define CMB_RX_EMPTY 4'h4
`define CMB_RX_FULL 4'h2
`define CMB_RX_OVR 4'h6
`define CMB_BUSY 4'h1
`define CMB_TX_INACT 4'h8
`define CMB_TX_SEND 4'hc
`define CMB_TX_RRESP 4'ha
`define CMB_TX_RSEND 4'he
// ==========================================
// reset values and limits
`define CMB_MASK_RST 16'hffff
`define CMB_MAX_LEN 4'h8
`define CMB_MOVE_LAST 3'h6
`define CMB_COPY_LAST 3'h4
// ==========================================
// bus field codes for overload detection
`define CMB_FLD_INTER 2'h1
`define CMB_FLD_EOF 2'h2
`define CMB_FLD_DELIM 2'h3
`define CMB_POS_INTER_LAST 3'h1
`define CMB_POS_EOF_LAST 3'h6
`define CMB_POS_DELIM_LAST 3'h7
`endif

// ==== src/cmb_mem.v ====
`timescale 1ns/1ns
// ==========================================
// two-port buffer memory, registered reads
module cmb_mem #(
    parameter DW = 16,
    parameter AW = 7
) (
    input wire clk,               // system clock
    input wire [AW-1:0] a_addr,   // host port address
    input wire a_we,              // host port write
    input wire [DW-1:0] a_wdata,  // host port write data
    output reg [DW-1:0] a_rdata,  // host port read data
    input wire [AW-1:0] b_addr,   // engine port address
    input wire b_we,              // engine port write
    input wire [DW-1:0] b_wdata,  // engine port write data
    output reg [DW-1:0] b_rdata   // engine port read data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // host write placed last so it wins a collision
    always @(posedge clk) begin
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        a_rdata <= mem[a_addr];
        b_rdata <= mem[b_addr];
    end
endmodule // cmb_mem

// ==== testbench/cmb_top_props.sv ====
`timescale 1ns/1ns
// ==========================================
// port checker
module cmb_top_chk (
    input wire I_CLOCK, // clock
    input wire I_NRST, // reset
    input wire I_RD, // read strobe
    input wire [15:0] O_RDATA, // read data
    input wire I_TX_DONE, // sent
    input wire I_TX_LOST, // abandoned
    input wire O_TX_REQ, // frame queued
    input wire [31:0] O_TX_ID, // tx id
    input wire [3:0] O_TX_LEN, // tx length
    input wire [63:0] O_TX_DATA, // tx data
    input wire I_BIT_VALID, // bit sample
    input wire I_BIT_DOM, // dominant
    input wire [1:0] I_FIELD, // field
    input wire [2:0] I_BIT_POS, // bit index
    input wire I_RX_FRAME, // received frame
    input wire O_OVERLOAD // overload start
);
    // qualifying overload bit
    wire ovl_q = I_BIT_VALID && I_BIT_DOM && ((I_FIELD == 2'h1 && I_BIT_POS < 3'h2)
        || (I_FIELD == 2'h2 && I_BIT_POS == 3'h6 && I_RX_FRAME)
        || (I_FIELD == 2'h3 && I_BIT_POS == 3'h7));
    wire busy = O_TX_REQ && !I_TX_DONE && !I_TX_LOST;
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_NRST);
    AST_LEN_MAX: assert property (O_TX_REQ |-> O_TX_LEN <= 4'h8)
        else $error("tx length above eight");
    AST_REQ_HOLD: assert property (busy |=> O_TX_REQ)
        else $error("tx request dropped early");
    AST_REQ_STABLE: assert property (busy |=> $stable({O_TX_ID, O_TX_LEN, O_TX_DATA}))
        else $error("tx frame changed while queued");
    AST_REQ_DROP: assert property (O_TX_REQ && (I_TX_DONE || I_TX_LOST) |=> !O_TX_REQ)
        else $error("tx request kept after end");
    AST_REQ_GAP: assert property ($fell(O_TX_REQ) |-> (!O_TX_REQ) [*8])
        else $error("tx request without selection");
    AST_OVL_FIRE: assert property (ovl_q |=> O_OVERLOAD)
        else $error("overload missed");
    AST_OVL_CAUSE: assert property (O_OVERLOAD |-> $past(ovl_q))
        else $error("overload without cause");
    AST_RD_IDLE: assert property (!I_RD |=> O_RDATA == 16'h0) // idle bus
        else $error("read data outside read");
    cover property ($rose(O_TX_REQ));
    cover property (O_TX_REQ && I_TX_DONE);
    cover property (O_OVERLOAD);
endmodule // cmb_top_chk
bind cmb_top cmb_top_chk u_chk (.I_CLOCK, .I_NRST, .I_RD, .O_RDATA, .I_TX_DONE, .I_TX_LOST,
    .O_TX_REQ, .O_TX_ID, .O_TX_LEN, .O_TX_DATA, .I_BIT_VALID, .I_BIT_DOM, .I_FIELD,
    .I_BIT_POS, .I_RX_FRAME, .O_OVERLOAD);

// ==== testbench/cmb_can_peer.sv ====
`timescale 1ns/1ns
// ==========================================
// far bus node: sends queued frame after dly cycles
module cmb_can_peer #(
    parameter [7:0] DLY = 8'h1e
) (
    input wire clk, // clock
    input wire nrst, // reset
    input wire req, // frame queued
    output reg bus_free, // bus idle
    output reg id_start, // id field begins
    output reg done // frame sent
);
    reg [7:0] cnt;
    // frame timing
    always @(posedge clk) begin
        cnt <= (!nrst || !req || done) ? 8'h0 : cnt + 8'h1;
        id_start <= req && cnt == 8'h2;
        done <= req && !done && cnt == DLY;
        bus_free <= nrst && !req;
    end
endmodule // cmb_can_peer

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
// ==========================================
// testbench
module tb;
    reg clk = 1'b0, nrst = 1'b0, we = 1'b0, re = 1'b0, bval = 1'b0, bdom = 1'b0;
    reg rxf = 1'b0, rxv = 1'b0;
    reg [7:0] addr = 8'h0;
    reg [15:0] wdata = 16'h0, rdv;
    reg [1:0] fld = 2'h0;
    reg [2:0] bpos = 3'h0;
    reg [3:0] rxlen = 4'h0;
    reg [31:0] rxid = 32'h0;
    reg [63:0] rxdata = 64'h0;
    wire [15:0] rdata;
    wire [31:0] tid;
    wire [3:0] tlen;
    wire [63:0] tdata;
    wire treq, ovl, bfree, ids, done;
    integer error_cnt = 0, n_compared = 0, cyc = 0, i, j, k;
    always #5 clk = ~clk;
    cmb_top uut (.I_CLOCK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(we),
        .I_RD(re), .O_RDATA(rdata), .I_BUS_FREE(bfree), .I_ID_START(ids), .I_TX_DONE(done),
        .I_TX_LOST(1'b0), .I_RX_VALID(rxv), .I_RX_ID(rxid), .I_RX_LEN(rxlen),
        .I_RX_DATA(rxdata), .O_TX_REQ(treq), .O_TX_ID(tid), .O_TX_LEN(tlen),
        .O_TX_DATA(tdata), .I_BIT_VALID(bval), .I_BIT_DOM(bdom), .I_FIELD(fld),
        .I_BIT_POS(bpos), .I_RX_FRAME(rxf), .O_OVERLOAD(ovl));
    cmb_can_peer peer (.clk(clk), .nrst(nrst), .req(treq), .bus_free(bfree),
        .id_start(ids), .done(done));
    task finish_test;
        begin
            $display("errors %0d compared %0d", error_cnt, n_compared);
            if (error_cnt == 0 && n_compared > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [63:0] g, input [63:0] e);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("Error t=%0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task wr(input [7:0] a, input [15:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            we <= 1'b1;
            @(posedge clk);
            we <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge clk);
            addr <= a;
            re <= 1'b1;
            @(posedge clk);
            re <= 1'b0;
            #1 rdv = rdata;
        end
    endtask
    task rc(input [7:0] a, input [15:0] e);
        begin
            rd(a);
            chk(rdv, e);
        end
    endtask
    // inactive, id, data, active
    task prep(input [7:0] b, input [15:0] hi, input [15:0] off, input [15:0] on);
        begin
            wr(b, off);
            wr(b + 8'h1, hi);
            wr(b + 8'h2, 16'h0);
            for (k = 3; k < 7; k = k + 1) wr(b + k[7:0], k == 3 ? 16'ha1b2 : 16'h0);
            wr(b, on);
        end
    endtask
    task rx(input r, input [3:0] l, input [63:0] d);
        begin
            @(posedge clk);
            rxid <= 32'h0abc0000 | r;
            rxlen <= l;
            rxdata <= d;
            rxv <= 1'b1;
            @(posedge clk);
            rxv <= 1'b0;
            repeat (12) @(posedge clk);
        end
    endtask
    task ovl_try(input [6:0] v);
        begin
            @(posedge clk);
            bval <= 1'b1;
            bdom <= v[0];
            rxf <= v[1];
            bpos <= v[4:2];
            fld <= v[6:5];
            @(posedge clk);
            bval <= 1'b0;
            #1 chk(ovl, v[0] && ((v[6:5] == 2'h1 && v[4:2] < 3'h2)
                || (v[6:5] == 2'h2 && v[4:2] == 3'h6 && v[1]) || (v[6:5] == 2'h3 && v[4:2] == 3'h7)));
        end
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            error_cnt = error_cnt + 1;
            finish_test;
        end
    end
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        prep(8'h10, 16'h1234, 16'h0000, 16'h0040);
        prep(8'h08, 16'h1234, 16'h0080, 16'h00c9);
        for (j = 0; j < 100 && treq !== 1'b1; j = j + 1) @(posedge clk);
        #1 chk(treq, 1'b1);
        chk(tlen, 4'h8);
        chk({tid, tdata[63:48]}, 48'h12340000a1b2);
        repeat (60) @(posedge clk);
        rc(8'h08, 16'h0089);
        rc(8'h10, 16'h0028);
        rc(8'h13, 16'ha1b2);
        rd(8'h80);
        wr(8'h28, 16'h00c1);
        wr(8'h28, 16'h0081);
        repeat (60) @(posedge clk);
        rc(8'h81, 16'h0006);
        prep(8'h18, 16'h0abc, 16'h0000, 16'h0040);
        prep(8'h20, 16'h0abc, 16'h0000, 16'h0040);
        rx(1'b0, 4'h4, 64'h1122334455667788);
        rc(8'h20, 16'h0040);
        rc(8'h18, 16'h0024);
        rc(8'h1b, 16'h1122);
        rx(1'b0, 4'h1, 64'h3300000000000000);
        rx(1'b0, 4'h2, 64'h4455000000000000);
        rc(8'h18, 16'h0024);
        rd(8'h80);
        rc(8'h18, 16'h0034);
        repeat (12) @(posedge clk);
        rc(8'h1b, 16'h4455);
        rc(8'h18, 16'h0062);
        prep(8'h30, 16'h0abc, 16'h0080, 16'h00a2);
        prep(8'h38, 16'h0abc, 16'h0080, 16'h0080);
        wr(8'h3a, 16'h0001);
        wr(8'h38, 16'h00c0);
        repeat (70) @(posedge clk);
        rc(8'h38, 16'h0040);
        rd(8'h80);
        rx(1'b1, 4'h2, 64'h0);
        repeat (70) @(posedge clk);
        rc(8'h30, 16'h00a2);
        rc(8'h38, 16'h0040);
        rc(8'h20, 16'h0022);
        rc(8'h81, 16'h00de);
        for (i = 0; i < 128; i = i + 1) ovl_try(i[6:0]);
        finish_test;
    end
endmodule // tb
